// [core/descrambler_config_regs.svh]
// register offsets, resets and field positions
`ifndef DESCRAMBLER_CONFIG_REGS_SVH
`define DESCRAMBLER_CONFIG_REGS_SVH
`define OFS_TX_SCRAMBLER_POLYNOMIAL_HIGH    16'h800E
`define OFS_TX_SCRAMBLER_POLYNOMIAL_LOW     16'h800F
`define OFS_RX_DESCR_ENABLES    16'h8019
`define OFS_RX_SEED_HIGH        16'h801C
`define OFS_RX_SEED_LOW         16'h801D
`define OFS_RX_POLY_HIGH        16'h801E
`define OFS_RX_POLY_LOW         16'h801F
`define OFS_AUTO_CHECK_CTRL     16'h8021
`define OFS_LS_TX_FAULT_CHAR    16'h8026
`define OFS_LS_RX_FAULT_CHAR    16'h8027
`define OFS_HS_RX_FAULT_CHAR    16'h8028
`define OFS_STARTUP_STATUS      16'h9020
`define RST_TX_SCRAMBLER_POLYNOMIAL_HIGH    16'h0000
`define RST_TX_SCRAMBLER_POLYNOMIAL_LOW     16'h00C0
`define RST_RX_DESCR_ENABLES    16'hFC00
`define RST_RX_SEED_HIGH        16'h0000
`define RST_RX_SEED_LOW         16'h01FC
`define RST_RX_POLY_HIGH        16'h0000
`define RST_RX_POLY_LOW         16'h00C0
`define RST_AUTO_CHECK_CTRL     16'h000A
`define RST_FAULT_CHAR          10'h2FE
`define RST_TX_SEED             32'h0000_01FC
`define BIT_POSTDEC_EN          0
`define BIT_PREDEC_EN           1
`define BIT_FLATLINE_ON_LOSS    3
`define BIT_SYNC_CHECK_OFF      4
`define BIT_LOSS_CHECK_OFF      5
`define BIT_PLL_CHECK_OFF       6
`define BIT_STARTUP_RUNNING     0
`define FORCED_ZERO_BIT         0
`define FAULT_CHAR_W            10
`endif

// [core/descrambler_config_pkg.sv]
// shared types of the configuration bank
package descrambler_config_pkg;
   typedef struct packed {
      logic [31:0] poly;
      logic [31:0] seed;
      logic        en;
   } scr_cfg_t;
   typedef struct packed {
      logic        pll_check_off;
      logic        loss_check_off;
      logic        sync_check_off;
      logic        flatline_on_loss;
   } auto_ctrl_t;
   typedef enum logic [1:0] {
      ST_RUNNING,
      ST_SETTLING,
      ST_COMPLETE
   } startup_state_t;
endpackage

// [core/lfsr_scrambler.sv]
// polynomial scrambler or self-synchronising descrambler with bypass
module lfsr_scrambler
   import descrambler_config_pkg::*;
#(
   parameter int W          = 20,
   parameter bit DESCRAMBLE = 1'b1
) (
   // clock and reset
   input  wire logic         mclk_in,
   input  wire logic         reset_in,
   // configuration
   input  wire scr_cfg_t     cfg_in,
   // stream
   input  wire logic [W-1:0] data_in,
   input  wire logic         valid_in,
   output logic      [W-1:0] data_out,
   output logic              valid_out
);
   logic [31:0]  state_r;
   logic [31:0]  chain [0:W];
   logic [W-1:0] mixed;

   assign chain[0] = state_r;
   for (genvar i = 0; i < W; i++) begin : g_bit
      wire fb = ^(chain[i] & cfg_in.poly);
      assign mixed[i] = data_in[i] ^ fb;
      // descrambler shifts in line bits so it resyncs itself
      assign chain[i+1] = {chain[i][30:0], DESCRAMBLE ? data_in[i] : mixed[i]};
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         state_r   <= 32'h0000_0000;
         data_out  <= '0;
         valid_out <= 1'b0;
      end else begin
         valid_out <= valid_in;
         if (!cfg_in.en)
            state_r <= cfg_in.seed;
         else if (valid_in)
            state_r <= chain[W];
         if (valid_in)
            data_out <= cfg_in.en ? mixed : data_in;
      end
   end
endmodule

// [core/fault_char_mux.sv]
// registered fault-character swap on a fifo error
module fault_char_mux #(
   parameter int W  = 20,
   parameter int CW = 10
) (
   // clock and reset
   input  wire logic          mclk_in,
   input  wire logic          reset_in,
   // fault control
   input  wire logic [CW-1:0] fault_char_in,
   input  wire logic          fifo_err_in,
   // stream
   input  wire logic [W-1:0]  data_in,
   input  wire logic          valid_in,
   output logic       [W-1:0] data_out,
   output logic               valid_out
);
   wire [W-1:0] fill = {(W/CW){fault_char_in}};

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         data_out  <= '0;
         valid_out <= 1'b0;
      end else begin
         valid_out <= valid_in | fifo_err_in;
         if (fifo_err_in)
            data_out <= fill;
         else if (valid_in)
            data_out <= data_in;
      end
   end
endmodule

// [core/descrambler_config_and_auto_control.sv]
// channel scrambler configuration, automatic check control and start-up status
`include "descrambler_config_regs.svh"
module descrambler_config_and_auto_control
   import descrambler_config_pkg::*;
#(
   parameter int          SETTLE_CYCLES = 16,
   parameter logic [31:0] TX_SEED       = `RST_TX_SEED
) (
   // clock and reset
   input  wire logic        mclk_in,
   input  wire logic        reset_in,
   // management register port
   input  wire logic [15:0] mgmt_addr_in,
   input  wire logic        mgmt_wr_in,
   input  wire logic [15:0] mgmt_wdata_in,
   input  wire logic        mgmt_rd_in,
   output logic      [15:0] mgmt_rdata_out,
   output logic             mgmt_rvalid_out,
   // transmit scramble enable from the transmit control bank
   input  wire logic        tx_postencoder_scramble_enable_in,
   // transmit path, encoder side to line
   input  wire logic [19:0] tx_enc_word_in,
   input  wire logic        tx_enc_valid_in,
   input  wire logic        ls_tx_fifo_err_in,
   output logic      [19:0] tx_line_word_out,
   output logic             tx_line_valid_out,
   // receive path ahead of the decoder
   input  wire logic [19:0] rx_line_word_in,
   input  wire logic        rx_line_valid_in,
   output logic      [19:0] rx_predec_word_out,
   output logic             rx_predec_valid_out,
   // receive path after the decoder
   input  wire logic [15:0] rx_dec_data_in,
   input  wire logic        rx_dec_valid_in,
   output logic      [15:0] rx_postdec_data_out,
   output logic             rx_postdec_valid_out,
   // highspeed receive fifo output
   input  wire logic [19:0] hs_rx_fifo_word_in,
   input  wire logic        hs_rx_fifo_valid_in,
   input  wire logic        hs_rx_fifo_err_in,
   output logic      [19:0] hs_rx_word_out,
   output logic             hs_rx_valid_out,
   // lowspeed receive fifo output
   input  wire logic [19:0] ls_rx_fifo_word_in,
   input  wire logic        ls_rx_fifo_valid_in,
   input  wire logic        ls_rx_fifo_err_in,
   output logic      [19:0] ls_rx_word_out,
   output logic             ls_rx_valid_out,
   // link health inputs
   input  wire logic        hs_pll_locked_in,
   input  wire logic        hs_signal_loss_in,
   input  wire logic        sync_ok_in,
   input  wire logic        clock_output_pin_sel_hs_in,
   // health and clock control outputs
   output logic             link_healthy_out,
   output logic             clock_output_pin_flatline_out,
   output logic             startup_protocol_running_out
);
   // register storage
   logic [15:0] tx_scrambler_poly_high_r;
   logic [15:0] tx_scrambler_poly_low_r;
   logic [15:0] rx_descrambler_enables_r;
   logic [15:0] rx_descrambler_seed_high_r;
   logic [15:0] rx_descrambler_seed_low_r;
   logic [15:0] rx_descrambler_poly_high_r;
   logic [15:0] rx_descrambler_poly_low_r;
   logic [15:0] automatic_check_control_r;
   logic [9:0]  lowspeed_tx_fault_char_r;
   logic [9:0]  lowspeed_rx_fault_char_r;
   logic [9:0]  highspeed_rx_fault_char_r;

   // address decode
   wire hit_tx_poly_high = mgmt_addr_in == `OFS_TX_SCRAMBLER_POLYNOMIAL_HIGH;
   wire hit_tx_poly_low  = mgmt_addr_in == `OFS_TX_SCRAMBLER_POLYNOMIAL_LOW;
   wire hit_rx_enables   = mgmt_addr_in == `OFS_RX_DESCR_ENABLES;
   wire hit_seed_high    = mgmt_addr_in == `OFS_RX_SEED_HIGH;
   wire hit_seed_low     = mgmt_addr_in == `OFS_RX_SEED_LOW;
   wire hit_poly_high    = mgmt_addr_in == `OFS_RX_POLY_HIGH;
   wire hit_poly_low     = mgmt_addr_in == `OFS_RX_POLY_LOW;
   wire hit_auto_ctrl    = mgmt_addr_in == `OFS_AUTO_CHECK_CTRL;
   wire hit_ls_tx_char   = mgmt_addr_in == `OFS_LS_TX_FAULT_CHAR;
   wire hit_ls_rx_char   = mgmt_addr_in == `OFS_LS_RX_FAULT_CHAR;
   wire hit_hs_rx_char   = mgmt_addr_in == `OFS_HS_RX_FAULT_CHAR;
   wire hit_status       = mgmt_addr_in == `OFS_STARTUP_STATUS;

   // bit zero of low polynomial and seed halves cannot be written high
   wire [15:0] wdata_even = {mgmt_wdata_in[15:1], 1'b0};
   wire [9:0]  wdata_char = mgmt_wdata_in[`FAULT_CHAR_W-1:0];

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         tx_scrambler_poly_high_r   <= `RST_TX_SCRAMBLER_POLYNOMIAL_HIGH;
         tx_scrambler_poly_low_r    <= `RST_TX_SCRAMBLER_POLYNOMIAL_LOW;
         rx_descrambler_enables_r   <= `RST_RX_DESCR_ENABLES;
         rx_descrambler_seed_high_r <= `RST_RX_SEED_HIGH;
         rx_descrambler_seed_low_r  <= `RST_RX_SEED_LOW;
         rx_descrambler_poly_high_r <= `RST_RX_POLY_HIGH;
         rx_descrambler_poly_low_r  <= `RST_RX_POLY_LOW;
         automatic_check_control_r  <= `RST_AUTO_CHECK_CTRL;
         lowspeed_tx_fault_char_r   <= `RST_FAULT_CHAR;
         lowspeed_rx_fault_char_r   <= `RST_FAULT_CHAR;
         highspeed_rx_fault_char_r  <= `RST_FAULT_CHAR;
      end else if (mgmt_wr_in) begin
         if (hit_tx_poly_high)
            tx_scrambler_poly_high_r <= mgmt_wdata_in;
         if (hit_tx_poly_low)
            tx_scrambler_poly_low_r <= wdata_even;
         if (hit_rx_enables)
            rx_descrambler_enables_r <= mgmt_wdata_in;
         if (hit_seed_high)
            rx_descrambler_seed_high_r <= mgmt_wdata_in;
         if (hit_seed_low)
            rx_descrambler_seed_low_r <= wdata_even;
         if (hit_poly_high)
            rx_descrambler_poly_high_r <= mgmt_wdata_in;
         if (hit_poly_low)
            rx_descrambler_poly_low_r <= wdata_even;
         if (hit_auto_ctrl)
            automatic_check_control_r <= mgmt_wdata_in;
         if (hit_ls_tx_char)
            lowspeed_tx_fault_char_r <= wdata_char;
         if (hit_ls_rx_char)
            lowspeed_rx_fault_char_r <= wdata_char;
         if (hit_hs_rx_char)
            highspeed_rx_fault_char_r <= wdata_char;
      end
   end

   // field views
   auto_ctrl_t auto_ctrl;
   assign auto_ctrl.pll_check_off    = automatic_check_control_r[`BIT_PLL_CHECK_OFF];
   assign auto_ctrl.loss_check_off   = automatic_check_control_r[`BIT_LOSS_CHECK_OFF];
   assign auto_ctrl.sync_check_off   = automatic_check_control_r[`BIT_SYNC_CHECK_OFF];
   assign auto_ctrl.flatline_on_loss = automatic_check_control_r[`BIT_FLATLINE_ON_LOSS];

   wire [31:0] tx_scrambler_polynomial = {tx_scrambler_poly_high_r, tx_scrambler_poly_low_r};
   wire [31:0] rx_descramble_seed = {rx_descrambler_seed_high_r, rx_descrambler_seed_low_r};
   wire [31:0] rx_descramble_polynomial =
      {rx_descrambler_poly_high_r, rx_descrambler_poly_low_r};
   wire rx_predecoder_descramble_enable  = rx_descrambler_enables_r[`BIT_PREDEC_EN];
   wire rx_postdecoder_descramble_enable = rx_descrambler_enables_r[`BIT_POSTDEC_EN];

   scr_cfg_t tx_cfg;
   scr_cfg_t rx20_cfg;
   scr_cfg_t rx16_cfg;
   assign tx_cfg   = '{poly: tx_scrambler_polynomial, seed: TX_SEED,
                       en: tx_postencoder_scramble_enable_in};
   assign rx20_cfg = '{poly: rx_descramble_polynomial, seed: rx_descramble_seed,
                       en: rx_predecoder_descramble_enable};
   // an all-zero seed does not stall the descrambler, which refills from line bits; reset loads 0x000001FC
   assign rx16_cfg = '{poly: rx_descramble_polynomial, seed: rx_descramble_seed,
                       en: rx_postdecoder_descramble_enable};

   // automatic checks; each off bit masks its own condition
   wire pll_ok  = auto_ctrl.pll_check_off | hs_pll_locked_in;
   wire loss_ok = auto_ctrl.loss_check_off | ~hs_signal_loss_in;
   wire sync_ok = auto_ctrl.sync_check_off | sync_ok_in;
   wire healthy = pll_ok & loss_ok & sync_ok;

   // start-up protocol sequencer
   startup_state_t state_r;
   startup_state_t state_nxt;
   logic [$clog2(SETTLE_CYCLES+1)-1:0] settle_r;
   localparam logic [$clog2(SETTLE_CYCLES+1)-1:0] SETTLE_LAST =
      ($clog2(SETTLE_CYCLES+1))'(SETTLE_CYCLES - 1);
   wire settle_done = settle_r == SETTLE_LAST;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_RUNNING:
            if (healthy)
               state_nxt = ST_SETTLING;
         ST_SETTLING:
            if (!healthy)
               state_nxt = ST_RUNNING;
            else if (settle_done)
               state_nxt = ST_COMPLETE;
         ST_COMPLETE:
            // a health drop restarts the whole protocol
            if (!healthy)
               state_nxt = ST_RUNNING;
         default:
            state_nxt = ST_RUNNING;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         state_r  <= ST_RUNNING;
         settle_r <= '0;
      end else begin
         state_r  <= state_nxt;
         settle_r <= (state_r == ST_SETTLING) ? settle_r + 1'b1 : '0;
      end
   end

   wire startup_running = state_r != ST_COMPLETE;

   // health and clock control outputs, registered
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         link_healthy_out              <= 1'b0;
         clock_output_pin_flatline_out <= 1'b0;
         startup_protocol_running_out  <= 1'b1;
      end else begin
         link_healthy_out              <= healthy;
         // only meaningful while the pin carries the recovered byte clock
         clock_output_pin_flatline_out <= auto_ctrl.flatline_on_loss & hs_signal_loss_in
                                          & clock_output_pin_sel_hs_in;
         startup_protocol_running_out  <= startup_running;
      end
   end

   // read mux; unmapped addresses read zero
   logic [15:0] rdata_sel;
   always_comb begin
      rdata_sel = 16'h0000;
      case (1'b1)
         hit_tx_poly_high: rdata_sel = tx_scrambler_poly_high_r;
         hit_tx_poly_low:  rdata_sel = tx_scrambler_poly_low_r;
         hit_rx_enables:   rdata_sel = rx_descrambler_enables_r;
         hit_seed_high:    rdata_sel = rx_descrambler_seed_high_r;
         hit_seed_low:     rdata_sel = rx_descrambler_seed_low_r;
         hit_poly_high:    rdata_sel = rx_descrambler_poly_high_r;
         hit_poly_low:     rdata_sel = rx_descrambler_poly_low_r;
         hit_auto_ctrl:    rdata_sel = automatic_check_control_r;
         hit_ls_tx_char:   rdata_sel = {6'h00, lowspeed_tx_fault_char_r};
         hit_ls_rx_char:   rdata_sel = {6'h00, lowspeed_rx_fault_char_r};
         hit_hs_rx_char:   rdata_sel = {6'h00, highspeed_rx_fault_char_r};
         hit_status:       rdata_sel = {15'h0000, startup_running};
         default:          rdata_sel = 16'h0000;
      endcase
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         mgmt_rdata_out  <= 16'h0000;
         mgmt_rvalid_out <= 1'b0;
      end else begin
         mgmt_rvalid_out <= mgmt_rd_in;
         if (mgmt_rd_in)
            mgmt_rdata_out <= rdata_sel;
      end
   end

   // transmit: scrambler after the encoder, then fault swap
   logic [19:0] tx_scr_word;
   logic        tx_scr_valid;
   lfsr_scrambler #(.W(20), .DESCRAMBLE(1'b0)) u_tx_scr (
      .mclk_in   (mclk_in),
      .reset_in  (reset_in),
      .cfg_in    (tx_cfg),
      .data_in   (tx_enc_word_in),
      .valid_in  (tx_enc_valid_in),
      .data_out  (tx_scr_word),
      .valid_out (tx_scr_valid)
   );

   fault_char_mux #(.W(20), .CW(`FAULT_CHAR_W)) u_tx_fault (
      .mclk_in       (mclk_in),
      .reset_in      (reset_in),
      .fault_char_in (lowspeed_tx_fault_char_r),
      .fifo_err_in   (ls_tx_fifo_err_in),
      .data_in       (tx_scr_word),
      .valid_in      (tx_scr_valid),
      .data_out      (tx_line_word_out),
      .valid_out     (tx_line_valid_out)
   );

   // receive: 20-bit descrambler ahead of the decoder
   lfsr_scrambler #(.W(20), .DESCRAMBLE(1'b1)) u_rx20 (
      .mclk_in   (mclk_in),
      .reset_in  (reset_in),
      .cfg_in    (rx20_cfg),
      .data_in   (rx_line_word_in),
      .valid_in  (rx_line_valid_in),
      .data_out  (rx_predec_word_out),
      .valid_out (rx_predec_valid_out)
   );

   // receive: 16-bit descrambler after the decoder
   lfsr_scrambler #(.W(16), .DESCRAMBLE(1'b1)) u_rx16 (
      .mclk_in   (mclk_in),
      .reset_in  (reset_in),
      .cfg_in    (rx16_cfg),
      .data_in   (rx_dec_data_in),
      .valid_in  (rx_dec_valid_in),
      .data_out  (rx_postdec_data_out),
      .valid_out (rx_postdec_valid_out)
   );

   fault_char_mux #(.W(20), .CW(`FAULT_CHAR_W)) u_hs_rx_fault (
      .mclk_in       (mclk_in),
      .reset_in      (reset_in),
      .fault_char_in (highspeed_rx_fault_char_r),
      .fifo_err_in   (hs_rx_fifo_err_in),
      .data_in       (hs_rx_fifo_word_in),
      .valid_in      (hs_rx_fifo_valid_in),
      .data_out      (hs_rx_word_out),
      .valid_out     (hs_rx_valid_out)
   );

   fault_char_mux #(.W(20), .CW(`FAULT_CHAR_W)) u_ls_rx_fault (
      .mclk_in       (mclk_in),
      .reset_in      (reset_in),
      .fault_char_in (lowspeed_rx_fault_char_r),
      .fifo_err_in   (ls_rx_fifo_err_in),
      .data_in       (ls_rx_fifo_word_in),
      .valid_in      (ls_rx_fifo_valid_in),
      .data_out      (ls_rx_word_out),
      .valid_out     (ls_rx_valid_out)
   );
endmodule

// [tb/config_bank_monitor.sv]
// port-level assertions for the channel configuration bank
module config_bank_monitor (
   // clock and reset
   input logic        mclk_in,
   input logic        reset_in,
   // register port
   input logic [15:0] mgmt_addr_in,
   input logic        mgmt_rd_in,
   input logic [15:0] mgmt_rdata_out,
   input logic        mgmt_rvalid_out,
   // fault paths
   input logic        ls_tx_fifo_err_in,
   input logic        hs_rx_fifo_err_in,
   input logic        ls_rx_fifo_err_in,
   input logic [19:0] tx_line_word_out,
   input logic        tx_line_valid_out,
   input logic [19:0] hs_rx_word_out,
   input logic        hs_rx_valid_out,
   input logic [19:0] ls_rx_word_out,
   input logic        ls_rx_valid_out,
   // health
   input logic        hs_signal_loss_in,
   input logic        clock_output_pin_sel_hs_in,
   input logic        link_healthy_out,
   input logic        clock_output_pin_flatline_out,
   input logic        startup_protocol_running_out
);
   timeunit 1ns;
   timeprecision 1ps;
   wire [15:0] rd_addr = mgmt_rd_in ? mgmt_addr_in : 16'h0000;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);
   AST_RVALID_ONE_CYCLE: assert property (mgmt_rvalid_out == $past(mgmt_rd_in))
      else $error("read valid timing");
   AST_TX_POLY_BIT0: assert property (rd_addr == 16'h800F |=> !mgmt_rdata_out[0])
      else $error("tx poly bit0");
   AST_SEED_BIT0: assert property (rd_addr == 16'h801D |=> !mgmt_rdata_out[0])
      else $error("seed bit0");
   AST_RX_POLY_BIT0: assert property (rd_addr == 16'h801F |=> !mgmt_rdata_out[0])
      else $error("rx poly bit0");
   AST_FAULT_CHAR_WIDTH: assert property (rd_addr inside {16'h8026, 16'h8027, 16'h8028}
      |=> mgmt_rdata_out[15:10] == 6'h00) else $error("fault char width");
   AST_STATUS_UPPER_ZERO: assert property (rd_addr == 16'h9020 |=>
      mgmt_rdata_out[15:1] == 15'h0000) else $error("status upper bits");
   AST_LS_TX_FAULT_WORD: assert property (ls_tx_fifo_err_in |=>
      tx_line_valid_out && tx_line_word_out[19:10] == tx_line_word_out[9:0])
      else $error("tx fault word");
   AST_HS_RX_FAULT_WORD: assert property (hs_rx_fifo_err_in |=> hs_rx_valid_out &&
      hs_rx_word_out[19:10] == hs_rx_word_out[9:0]) else $error("hs fault word");
   AST_LS_RX_FAULT_WORD: assert property (ls_rx_fifo_err_in |=> ls_rx_valid_out &&
      ls_rx_word_out[19:10] == ls_rx_word_out[9:0]) else $error("ls fault word");
   AST_FLAT_NEEDS_LOSS: assert property (
      !(hs_signal_loss_in && clock_output_pin_sel_hs_in) |=> !clock_output_pin_flatline_out)
      else $error("flatline without loss");
   AST_UNHEALTHY_RESTARTS: assert property (
      !link_healthy_out [*3] |-> startup_protocol_running_out)
      else $error("start-up not restarted");
endmodule
bind descrambler_config_and_auto_control config_bank_monitor u_mon (.*);

// [tb/line_partner_model.sv]
// far-end model driving the receive line
module line_partner_model (
   // clock and reset
   input  wire logic        mclk_in,
   input  wire logic        reset_in,
   // word to send
   input  wire logic        send_in,
   input  wire logic [19:0] word_in,
   // receive line
   output logic      [19:0] line_word_out,
   output logic             line_valid_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // idle line toggles so a stale word never passes for data
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         line_word_out  <= 20'h0_0000;
         line_valid_out <= 1'b0;
      end else if (send_in) begin
         line_word_out  <= word_in;
         line_valid_out <= 1'b1;
      end else begin
         line_word_out  <= ~line_word_out;
         line_valid_out <= 1'b0;
      end
   end
endmodule

// [tb/tb_top.sv]
// self-checking bench for the channel configuration bank
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin mismatches++; \
   $display("unexpected %s expected %h seen %h", n, e, s); end end
   logic        mclk_in = 1'b0, reset_in = 1'b1, mgmt_wr_in = 1'b0, mgmt_rd_in = 1'b0;
   logic [15:0] mgmt_addr_in = 16'h0000, mgmt_wdata_in = 16'h0000, mgmt_rdata_out, rv;
   logic        mgmt_rvalid_out, tx_postencoder_scramble_enable_in = 1'b0, send = 1'b0;
   logic        tx_enc_valid_in = 1'b0, ls_tx_fifo_err_in = 1'b0, tx_line_valid_out;
   logic [19:0] tx_enc_word_in = 20'h0_0000, tx_line_word_out, rx_line_word_in, send_word;
   logic [19:0] rx_predec_word_out, hs_rx_word_out, ls_rx_word_out, pw, tw, hw, lw;
   logic [19:0] hs_rx_fifo_word_in = 20'h0_0000, ls_rx_fifo_word_in = 20'h0_0000;
   logic        rx_line_valid_in, rx_predec_valid_out, rx_dec_valid_in = 1'b0;
   logic [15:0] rx_dec_data_in = 16'h0000, rx_postdec_data_out, pd;
   logic        rx_postdec_valid_out, hs_rx_valid_out, ls_rx_valid_out, link_healthy_out;
   logic        hs_rx_fifo_valid_in = 1'b0, hs_rx_fifo_err_in = 1'b0;
   logic        ls_rx_fifo_valid_in = 1'b0, ls_rx_fifo_err_in = 1'b0;
   logic        hs_pll_locked_in = 1'b0, hs_signal_loss_in = 1'b0, sync_ok_in = 1'b0;
   logic        clock_output_pin_sel_hs_in = 1'b0, clock_output_pin_flatline_out;
   logic        startup_protocol_running_out;
   int          mismatches = 0, samples_checked = 0, cycles = 0;
   typedef struct packed {logic [15:0] a, rst, wd, rb;} row_t;
   typedef struct packed {logic [15:0] ctl; logic [3:0] lvl; logic [1:0] exp;} hrow_t;
   row_t rows [13] = '{
      '{16'h800E, 16'h0000, 16'hFFFF, 16'hFFFF},
      '{16'h800F, 16'h00C0, 16'hFFFF, 16'hFFFE},
      '{16'h8019, 16'hFC00, 16'hAAAA, 16'hAAAA},
      '{16'h801C, 16'h0000, 16'hFFFF, 16'hFFFF},
      '{16'h801D, 16'h01FC, 16'hFFFF, 16'hFFFE},
      '{16'h801E, 16'h0000, 16'hFFFF, 16'hFFFF},
      '{16'h801F, 16'h00C0, 16'hFFFF, 16'hFFFE},
      '{16'h8021, 16'h000A, 16'hAA80, 16'hAA80},
      '{16'h8026, 16'h02FE, 16'hFFFF, 16'h03FF},
      '{16'h8027, 16'h02FE, 16'hFFFF, 16'h03FF},
      '{16'h8028, 16'h02FE, 16'hFFFF, 16'h03FF},
      '{16'h9020, 16'h0001, 16'hFFFF, 16'h0001},
      '{16'h8030, 16'h0000, 16'hFFFF, 16'h0000}};
   // levels: pll, loss, sync, sel; expect: healthy, flatline
   hrow_t hrows [9] = '{'{16'h000A, 4'b1011, 2'b10}, '{16'h000A, 4'b0011, 2'b00},
      '{16'h004A, 4'b0011, 2'b10}, '{16'h000A, 4'b1111, 2'b01},
      '{16'h002A, 4'b1111, 2'b11}, '{16'h002A, 4'b1110, 2'b10},
      '{16'h0002, 4'b1111, 2'b00}, '{16'h000A, 4'b1001, 2'b00},
      '{16'h001A, 4'b1001, 2'b10}};
   descrambler_config_and_auto_control #(.SETTLE_CYCLES(2)) u_dut (.*);
   line_partner_model u_line (.mclk_in, .reset_in, .send_in(send), .word_in(send_word),
      .line_word_out(rx_line_word_in), .line_valid_out(rx_line_valid_in));
   initial begin
      forever #5 mclk_in = ~mclk_in;
   end
   // run takes ~175 cycles
   always @(posedge mclk_in) begin
      if (++cycles == 3000) begin
         mismatches++;
         print_verdict();
      end
   end
   function automatic logic [19:0] scr(input logic [19:0] d, input int n,
                                       input logic [31:0] s, p, input bit tx);
      logic [19:0] o;
      logic [31:0] st;
      o = 20'h0_0000;
      st = s;
      for (int i = 0; i < n; i++) begin
         o[i] = d[i] ^ (^(st & p));
         st = {st[30:0], tx ? o[i] : d[i]};
      end
      return o;
   endfunction
   task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge mclk_in);
      mgmt_addr_in <= a;
      mgmt_wdata_in <= d;
      mgmt_wr_in <= 1'b1;
      @(posedge mclk_in);
      mgmt_wr_in <= 1'b0;
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
      @(posedge mclk_in);
      mgmt_addr_in <= a;
      mgmt_rd_in <= 1'b1;
      @(posedge mclk_in);
      mgmt_rd_in <= 1'b0;
      #1;
      `CHK("rvalid", 1'b1, mgmt_rvalid_out)
      `CHK("rdata", e, mgmt_rdata_out)
   endtask
   // tx error held two cycles
   task automatic stream(input logic err, input logic [19:0] w, input logic [15:0] d);
      @(posedge mclk_in);
      {tx_enc_valid_in, rx_dec_valid_in, hs_rx_fifo_valid_in, ls_rx_fifo_valid_in} <= 4'hF;
      {ls_tx_fifo_err_in, hs_rx_fifo_err_in, ls_rx_fifo_err_in, send} <= {{3{err}}, 1'b1};
      {tx_enc_word_in, hs_rx_fifo_word_in, ls_rx_fifo_word_in, send_word} <= {4{w}};
      rx_dec_data_in <= d;
      @(posedge mclk_in);
      {tx_enc_valid_in, rx_dec_valid_in, hs_rx_fifo_valid_in, ls_rx_fifo_valid_in} <= 4'h0;
      {hs_rx_fifo_err_in, ls_rx_fifo_err_in, send} <= 3'h0;
      #1;
      `CHK("postdec valid", 1'b1, rx_postdec_valid_out)
      `CHK("hs valid", 1'b1, hs_rx_valid_out)
      `CHK("ls valid", 1'b1, ls_rx_valid_out)
      {pd, hw, lw} = {rx_postdec_data_out, hs_rx_word_out, ls_rx_word_out};
      @(posedge mclk_in);
      ls_tx_fifo_err_in <= 1'b0;
      #1;
      `CHK("predec valid", 1'b1, rx_predec_valid_out)
      `CHK("tx valid", 1'b1, tx_line_valid_out)
      {pw, tw} = {rx_predec_word_out, tx_line_word_out};
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge mclk_in);
      reset_in <= 1'b0;
      foreach (rows[i]) begin
         rd_chk(rows[i].a, rows[i].rst);
         reg_wr(rows[i].a, rows[i].wd);
         rd_chk(rows[i].a, rows[i].rb);
      end
      $display("test register map done");
      @(posedge mclk_in);
      reset_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      reset_in <= 1'b0;
      #1;
      `CHK("running after reset", 1'b1, startup_protocol_running_out)
      stream(1'b0, 20'hA_5C3E, 16'h9B71);
      `CHK("paths bypassed", {4{20'hA_5C3E}}, {pw, hw, lw, tw})
      `CHK("postdec bypassed", 16'h9B71, pd)
      reg_wr(16'h8026, 16'h0155);
      reg_wr(16'h8027, 16'h02AA);
      reg_wr(16'h8028, 16'h0333);
      stream(1'b1, 20'h1_2345, 16'h0000);
      `CHK("tx fault", {2{10'h155}}, tw)
      `CHK("ls rx fault", {2{10'h2AA}}, lw)
      `CHK("hs rx fault", {2{10'h333}}, hw)
      $display("test fault characters done");
      reg_wr(16'h801C, 16'h1234);
      reg_wr(16'h801D, 16'h5679);
      reg_wr(16'h801E, 16'h0040);
      reg_wr(16'h801F, 16'h8001);
      reg_wr(16'h800E, 16'h0800);
      reg_wr(16'h800F, 16'h0305);
      reg_wr(16'h8019, 16'hFC03);
      tx_postencoder_scramble_enable_in <= 1'b1;
      stream(1'b0, 20'hC_3A96, 16'h5AC3);
      `CHK("predec", scr(20'hC_3A96, 20, 32'h1234_5678, 32'h0040_8000, 1'b0), pw)
      `CHK("postdec", 16'(scr(20'h0_5AC3, 16, 32'h1234_5678, 32'h0040_8000, 1'b0)), pd)
      `CHK("tx scrambled", scr(20'hC_3A96, 20, 32'h0000_01FC, 32'h0800_0304, 1'b1), tw)
      $display("test scramblers done");
      foreach (hrows[i]) begin
         reg_wr(16'h8021, hrows[i].ctl);
         {hs_pll_locked_in, hs_signal_loss_in, sync_ok_in, clock_output_pin_sel_hs_in}
            <= hrows[i].lvl;
         repeat (2) @(posedge mclk_in);
         #1;
         `CHK("health", hrows[i].exp, {link_healthy_out, clock_output_pin_flatline_out})
      end
      $display("test automatic checks done");
      repeat (8) @(posedge mclk_in);
      rd_chk(16'h9020, 16'h0000);
      `CHK("running port", 1'b0, startup_protocol_running_out)
      @(posedge mclk_in);
      hs_pll_locked_in <= 1'b0;
      repeat (3) @(posedge mclk_in);
      rd_chk(16'h9020, 16'h0001);
      $display("test start-up status done");
      print_verdict();
   end
endmodule
